// *** rtl/apc_pkg.sv ***
// Constants, field layout and types shared by the record-path and synthesizer register bank.
package apc_pkg;

   // Register addresses on the two-wire control port.
   localparam logic [7:0] REG_CTRL_TWO   = 8'h6F;
   localparam logic [7:0] REG_LEFT_GAIN  = 8'h70;
   localparam logic [7:0] REG_RIGHT_GAIN = 8'h71;
   localparam logic [7:0] REG_LEFT_PEAK  = 8'h72;
   localparam logic [7:0] REG_RIGHT_PEAK = 8'h73;
   localparam logic [7:0] REG_SYNTH_ONE  = 8'h74;
   localparam logic [7:0] REG_SYNTH_TWO  = 8'h75;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] ADDR_STEP      = 8'h01;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // Field positions, widths and masks.
   localparam int         FIELD2_W     = 2;
   localparam int         CT2_DIV_LSB  = 0;
   localparam int         CT2_SLEEP    = 4;
   localparam logic [7:0] CT2_MASK     = 8'h13;
   localparam logic [1:0] PEAK_PAD     = 2'h0;
   localparam int         S1_SRC_LSB   = 6;
   localparam int         S1_OUT_HALVE = 5;
   localparam int         S1_REF_HALVE = 4;
   localparam int         S1_B_SLEEP   = 3;
   localparam int         S1_A_SLEEP   = 2;
   localparam int         S1_OSC_SLEEP = 1;
   localparam int         S1_RATIO     = 0;
   localparam int         S2_B_LSB     = 6;
   localparam int         S2_B_RATIO   = 5;
   localparam int         S2_B_DOUBLE  = 4;
   localparam int         S2_A_LSB     = 2;
   localparam int         S2_A_RATIO   = 1;
   localparam int         S2_A_DOUBLE  = 0;
   localparam int         GAIN_MSB     = 6;

   // Divider codes and division ratios.
   localparam logic [1:0] DIV_CODE_BY2 = 2'h1;
   localparam logic [1:0] DIV_CODE_BY3 = 2'h2;
   localparam logic [1:0] DIV_ONE      = 2'h1;
   localparam logic [1:0] DIV_TWO      = 2'h2;
   localparam logic [1:0] DIV_THREE    = 2'h3;

   // Third system clock source codes.
   localparam logic [1:0] SRC_SYNTH = 2'h0;
   localparam logic [1:0] SRC_RX    = 2'h3;

   // Sample rate codes, rates in hertz and oversampling ratios.
   localparam logic [1:0]  RATE_48K  = 2'h0;
   localparam logic [1:0]  RATE_32K  = 2'h2;
   localparam logic [1:0]  RATE_44K1 = 2'h3;
   localparam logic [16:0] HZ_NONE   = 17'h00000;
   localparam logic [16:0] HZ_48K    = 17'h0BB80;
   localparam logic [16:0] HZ_32K    = 17'h07D00;
   localparam logic [16:0] HZ_44K1   = 17'h0AC44;
   localparam logic [16:0] HZ_88K2   = 17'h15888;
   localparam logic [9:0]  OSR_256   = 10'h100;
   localparam logic [9:0]  OSR_384   = 10'h180;
   localparam logic [9:0]  OSR_512   = 10'h200;

   // Linear gain codes and numerators in units of 1/256.
   localparam logic [6:0] GAIN_CODE_MAX  = 7'h7F;
   localparam logic [6:0] GAIN_CODE_HALF = 7'h40;
   localparam logic [6:0] GAIN_CODE_MIN  = 7'h00;
   localparam logic [8:0] GAIN_UNITY     = 9'h100;
   localparam logic [8:0] GAIN_HALF      = 9'h080;
   localparam logic [8:0] GAIN_MIN       = 9'h001;

   // Control port framing; the device address value is arbitrary.
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C;
   localparam logic [2:0] BIT_FIRST        = 3'h0;
   localparam logic [2:0] BIT_STEP         = 3'h1;
   localparam logic [2:0] BIT_LAST         = 3'h7;

   // Control port engine states, Gray coded along the usual path.
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_DEV     = 4'h1,
      ST_DEV_ACK = 4'h3,
      ST_SUB     = 4'h2,
      ST_SUB_ACK = 4'h6,
      ST_WR      = 4'h7,
      ST_WR_ACK  = 4'h5,
      ST_RD      = 4'h4,
      ST_RD_ACK  = 4'hC
   } apc_state_t;

endpackage : apc_pkg

// *** rtl/apc_sync2.sv ***
// Two flip-flop synchroniser for the control port pins.
module apc_sync2 (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [1:0] d,
   output logic      [1:0] q
);
   import apc_pkg::*;

   logic [1:0] meta_q;

   // The first stage feeds only the second; idle bus level is high.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q <= 2'h3;
         q      <= 2'h3;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : apc_sync2

// *** rtl/apc_synth_decode.sv ***
// Registered decode of one synthesizer's rate, oversampling and doubling fields.
module apc_synth_decode (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [1:0]  rate_code,
   input  wire logic        ratio_sel,
   input  wire logic        double_sel,
   output logic      [16:0] rate_hz,
   output logic      [9:0]  os_ratio,
   output logic             rate_bad
);
   import apc_pkg::*;

   logic [16:0] base_hz;

   // Base rate from the code; the reserved code gives no rate.
   always_comb begin
      unique case (rate_code)
         RATE_48K:  base_hz = HZ_48K;
         RATE_32K:  base_hz = HZ_32K;
         RATE_44K1: base_hz = HZ_44K1;
         default:   base_hz = HZ_NONE;
      endcase
   end

   // Doubling shifts the rate; the ratio picks the higher multiple when set.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rate_hz  <= HZ_48K;
         os_ratio <= OSR_256;
         rate_bad <= 1'b0;
      end else begin
         rate_hz  <= double_sel ? {base_hz[15:0], 1'b0} : base_hz;
         os_ratio <= ratio_sel ? OSR_384 : OSR_256;
         rate_bad <= (base_hz == HZ_NONE);
      end
   end

endmodule : apc_synth_decode

// *** rtl/apc_regbank.sv ***
// Record-path and clock synthesizer control register bank behind a two-wire control port.

//
// Behaviour
// - Clock divider code 00 and 11 divide by one, 01 by two, 10 by three.
// - Reference buffer sleep bit set powers the buffer down, clear runs normally.
// - Left gain code scales linearly: all ones unity, 1000000 half, zero minimum.
// - Right gain code scales like left: all ones unity, zero minimum gain.
// - Left peak readback is six bits, 1 dB per step below full scale.
// - Right peak readback uses the same six-bit decibel encoding.
// - Third clock source 00 takes the synthesizer, 11 the receiver clock.
// - Clock out halve bit set halves the master clock output frequency.
// - Synthesizer reference halve bit set halves the crystal input clock.
// - Third system clock ratio bit zero gives 512, one gives 256 times.
// - Second synthesizer rate: 00 48k, 10 32k, 11 44.1k, 01 reserved.
// - Second synthesizer ratio bit: zero 256, one 384 times the rate.
// - Second synthesizer double bit set doubles its selected sample rate.
// - First synthesizer rate: 00 48k, 10 32k, 11 44.1k, 01 reserved.
// - First synthesizer ratio bit: zero 256, one a higher ratio.
// - Synthesizer reference select: zero crystal input, one master clock.
module apc_regbank #(
   parameter logic [6:0] DEV_ADDR = apc_pkg::DEV_ADDR_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic [5:0]  record_left_peak_code,
   input  wire logic [5:0]  record_right_peak_code,
   input  wire logic        synth_ref_select,
   output logic      [1:0]  record_clock_divider,
   output logic      [1:0]  record_div_ratio,
   output logic             ref_buffer_sleep,
   output logic      [7:0]  record_left_gain_code,
   output logic      [7:0]  record_right_gain_code,
   output logic      [8:0]  record_left_gain_num,
   output logic      [8:0]  record_right_gain_num,
   output logic      [1:0]  third_sysclk_source,
   output logic             third_sysclk_from_rx,
   output logic      [9:0]  third_sysclk_ratio,
   output logic      [1:0]  master_clock_div,
   output logic      [1:0]  synth_ref_div,
   output logic             synth_ref_from_mclk,
   output logic             synth_a_sleep,
   output logic             synth_b_sleep,
   output logic             oscillator_sleep,
   output logic      [16:0] synth_a_rate_hz,
   output logic      [9:0]  synth_a_os_ratio,
   output logic             synth_a_rate_bad,
   output logic      [16:0] synth_b_rate_hz,
   output logic      [9:0]  synth_b_os_ratio,
   output logic             synth_b_rate_bad
);
   import apc_pkg::*;

   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       scl_d_q;
   logic       sda_d_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   apc_state_t state_q;
   logic [2:0] cnt_q;
   logic [7:0] shreg_q;
   logic       full_q;
   logic       rw_q;
   logic       mack_q;
   logic [7:0] sub_q;
   logic       oe_q;
   logic       wr_stb;
   logic [7:0] rd_now;
   logic [7:0] ctrl2_q;
   logic [7:0] lgain_q;
   logic [7:0] rgain_q;
   logic [7:0] synth1_q;
   logic [7:0] synth2_q;

   // Division ratio for the record converter master clock divider code.
   function automatic logic [1:0] div_ratio(input logic [1:0] code);
      unique case (code)
         DIV_CODE_BY2: div_ratio = DIV_TWO;
         DIV_CODE_BY3: div_ratio = DIV_THREE;
         default:      div_ratio = DIV_ONE;
      endcase
   endfunction : div_ratio

   // Linear gain numerator over 256 for a seven-bit volume code.
   function automatic logic [8:0] gain_num(input logic [6:0] code);
      if (code == GAIN_CODE_MAX) begin
         gain_num = GAIN_UNITY;
      end else if (code == GAIN_CODE_MIN) begin
         gain_num = GAIN_MIN;
      end else begin
         gain_num = {1'b0, code, 1'b0};
      end
   endfunction : gain_num

   // Read value at a register address; peak codes are sampled live.
   function automatic logic [7:0] rd_byte(input logic [7:0] a);
      unique case (a)
         REG_CTRL_TWO:   rd_byte = ctrl2_q;
         REG_LEFT_GAIN:  rd_byte = lgain_q;
         REG_RIGHT_GAIN: rd_byte = rgain_q;
         REG_LEFT_PEAK:  rd_byte = {PEAK_PAD, record_left_peak_code};
         REG_RIGHT_PEAK: rd_byte = {PEAK_PAD, record_right_peak_code};
         REG_SYNTH_ONE:  rd_byte = synth1_q;
         REG_SYNTH_TWO:  rd_byte = synth2_q;
         default:        rd_byte = READ_ZERO;
      endcase
   endfunction : rd_byte

   // Pin synchroniser; logic reads only its second stage.
   apc_sync2 u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({scl_i, sda_i}),
      .q    (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Delayed pin copies for edge and framing detection.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end

   // Clock edges, start and stop conditions, and the write strobe.
   assign scl_rise = scl_s & ~scl_d_q;
   assign scl_fall = ~scl_s & scl_d_q;
   assign start_c  = scl_s & scl_d_q & sda_d_q & ~sda_s;
   assign stop_c   = scl_s & scl_d_q & ~sda_d_q & sda_s;
   assign wr_stb   = scl_fall & full_q & (state_q == ST_WR);

   // Read value lookup; a process, so that live register and peak code changes are seen at once.
   always_comb begin
      rd_now = rd_byte(sub_q);
   end

   // The data line is open drain: only a low level is ever driven.
   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;

   // Control port engine: bits are sampled on rising clock and driven on falling clock.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         cnt_q   <= BIT_FIRST;
         shreg_q <= RST_BYTE;
         full_q  <= 1'b0;
         rw_q    <= 1'b0;
         mack_q  <= 1'b0;
         sub_q   <= RST_BYTE;
         oe_q    <= 1'b0;
      end else if (start_c) begin
         state_q <= ST_DEV;
         cnt_q   <= BIT_FIRST;
         full_q  <= 1'b0;
         oe_q    <= 1'b0;
      end else if (stop_c) begin
         state_q <= ST_IDLE;
         full_q  <= 1'b0;
         oe_q    <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_q)
            ST_DEV, ST_SUB, ST_WR: begin
               shreg_q <= {shreg_q[6:0], sda_s};
               cnt_q   <= cnt_q + BIT_STEP;
               full_q  <= (cnt_q == BIT_LAST);
            end
            ST_RD: begin
               cnt_q  <= cnt_q + BIT_STEP;
               full_q <= (cnt_q == BIT_LAST);
            end
            ST_RD_ACK: begin
               mack_q <= ~sda_s;
            end
            default: begin
               full_q <= full_q;
            end
         endcase
      end else if (scl_fall) begin
         unique case (state_q)
            ST_DEV: begin
               if (full_q) begin
                  full_q <= 1'b0;
                  rw_q   <= shreg_q[0];
                  if (shreg_q[7:1] == DEV_ADDR) begin
                     state_q <= ST_DEV_ACK;
                     oe_q    <= 1'b1;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_DEV_ACK: begin
               cnt_q <= BIT_FIRST;
               if (rw_q) begin
                  state_q <= ST_RD;
                  shreg_q <= rd_now;
                  sub_q   <= sub_q + ADDR_STEP;
                  oe_q    <= ~rd_now[7];
               end else begin
                  state_q <= ST_SUB;
                  oe_q    <= 1'b0;
               end
            end
            ST_SUB: begin
               if (full_q) begin
                  full_q  <= 1'b0;
                  sub_q   <= shreg_q;
                  state_q <= ST_SUB_ACK;
                  oe_q    <= 1'b1;
               end
            end
            ST_SUB_ACK: begin
               cnt_q   <= BIT_FIRST;
               state_q <= ST_WR;
               oe_q    <= 1'b0;
            end
            ST_WR: begin
               if (full_q) begin
                  full_q  <= 1'b0;
                  state_q <= ST_WR_ACK;
                  oe_q    <= 1'b1;
               end
            end
            ST_WR_ACK: begin
               cnt_q   <= BIT_FIRST;
               sub_q   <= sub_q + ADDR_STEP;
               state_q <= ST_WR;
               oe_q    <= 1'b0;
            end
            ST_RD: begin
               if (full_q) begin
                  full_q  <= 1'b0;
                  state_q <= ST_RD_ACK;
                  oe_q    <= 1'b0;
               end else begin
                  shreg_q <= {shreg_q[6:0], 1'b0};
                  oe_q    <= ~shreg_q[6];
               end
            end
            ST_RD_ACK: begin
               cnt_q <= BIT_FIRST;
               if (mack_q) begin
                  state_q <= ST_RD;
                  shreg_q <= rd_now;
                  sub_q   <= sub_q + ADDR_STEP;
                  oe_q    <= ~rd_now[7];
               end else begin
                  state_q <= ST_IDLE;
                  oe_q    <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               oe_q    <= 1'b0;
            end
         endcase
      end
   end

   // Writable registers; reserved bits of the converter control register stay zero.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl2_q  <= RST_BYTE;
         lgain_q  <= RST_BYTE;
         rgain_q  <= RST_BYTE;
         synth1_q <= RST_BYTE;
         synth2_q <= RST_BYTE;
      end else if (wr_stb) begin
         unique case (sub_q)
            REG_CTRL_TWO:   ctrl2_q  <= shreg_q & CT2_MASK;
            REG_LEFT_GAIN:  lgain_q  <= shreg_q;
            REG_RIGHT_GAIN: rgain_q  <= shreg_q;
            REG_SYNTH_ONE:  synth1_q <= shreg_q;
            REG_SYNTH_TWO:  synth2_q <= shreg_q;
            default:        ctrl2_q  <= ctrl2_q;
         endcase
      end
   end

   // Field outputs toward the converter, clock tree and synthesizers.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         record_clock_divider   <= RST_BYTE[1:0];
         record_div_ratio       <= DIV_ONE;
         ref_buffer_sleep       <= 1'b0;
         record_left_gain_code  <= RST_BYTE;
         record_right_gain_code <= RST_BYTE;
         record_left_gain_num   <= GAIN_MIN;
         record_right_gain_num  <= GAIN_MIN;
         third_sysclk_source    <= SRC_SYNTH;
         third_sysclk_from_rx   <= 1'b0;
         third_sysclk_ratio     <= OSR_512;
         master_clock_div       <= DIV_ONE;
         synth_ref_div          <= DIV_ONE;
         synth_ref_from_mclk    <= 1'b0;
         synth_a_sleep          <= 1'b0;
         synth_b_sleep          <= 1'b0;
         oscillator_sleep       <= 1'b0;
      end else begin
         record_clock_divider   <= ctrl2_q[CT2_DIV_LSB +: FIELD2_W];
         record_div_ratio       <= div_ratio(ctrl2_q[CT2_DIV_LSB +: FIELD2_W]);
         ref_buffer_sleep       <= ctrl2_q[CT2_SLEEP];
         record_left_gain_code  <= lgain_q;
         record_right_gain_code <= rgain_q;
         record_left_gain_num   <= gain_num(lgain_q[GAIN_MSB:0]);
         record_right_gain_num  <= gain_num(rgain_q[GAIN_MSB:0]);
         third_sysclk_source    <= synth1_q[S1_SRC_LSB +: FIELD2_W];
         third_sysclk_from_rx   <= (synth1_q[S1_SRC_LSB +: FIELD2_W] == SRC_RX);
         third_sysclk_ratio     <= synth1_q[S1_RATIO] ? OSR_256 : OSR_512;
         master_clock_div       <= synth1_q[S1_OUT_HALVE] ? DIV_TWO : DIV_ONE;
         synth_ref_div          <= (synth1_q[S1_REF_HALVE] & ~synth_ref_select) ? DIV_TWO : DIV_ONE;
         synth_ref_from_mclk    <= synth_ref_select;
         synth_a_sleep          <= synth1_q[S1_A_SLEEP];
         synth_b_sleep          <= synth1_q[S1_B_SLEEP];
         oscillator_sleep       <= synth1_q[S1_OSC_SLEEP];
      end
   end

   // First synthesizer rate, ratio and doubling decode.
   apc_synth_decode u_synth_a (
      .clk        (clk),
      .nrst       (nrst),
      .rate_code  (synth2_q[S2_A_LSB +: FIELD2_W]),
      .ratio_sel  (synth2_q[S2_A_RATIO]),
      .double_sel (synth2_q[S2_A_DOUBLE]),
      .rate_hz    (synth_a_rate_hz),
      .os_ratio   (synth_a_os_ratio),
      .rate_bad   (synth_a_rate_bad)
   );

   // Second synthesizer rate, ratio and doubling decode.
   apc_synth_decode u_synth_b (
      .clk        (clk),
      .nrst       (nrst),
      .rate_code  (synth2_q[S2_B_LSB +: FIELD2_W]),
      .ratio_sel  (synth2_q[S2_B_RATIO]),
      .double_sel (synth2_q[S2_B_DOUBLE]),
      .rate_hz    (synth_b_rate_hz),
      .os_ratio   (synth_b_os_ratio),
      .rate_bad   (synth_b_rate_bad)
   );

   // Checks that tie register writes and reads to the field outputs.
   a_div_ratio_map: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_CTRL_TWO && shreg_q[CT2_DIV_LSB +: FIELD2_W] == DIV_CODE_BY3
      |-> ##2 record_div_ratio == DIV_THREE) else $error("divider code 10 did not give three");
   a_buf_sleep_set: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_CTRL_TWO && shreg_q[CT2_SLEEP]
      |-> ##2 ref_buffer_sleep [*2]) else $error("buffer sleep did not follow write");
   a_left_gain_unity: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_LEFT_GAIN && shreg_q[GAIN_MSB:0] == GAIN_CODE_MAX
      |-> ##2 record_left_gain_num == GAIN_UNITY) else $error("left full code not unity");
   a_right_gain_half: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_RIGHT_GAIN && shreg_q[GAIN_MSB:0] == GAIN_CODE_HALF
      |-> ##2 record_right_gain_num == GAIN_HALF) else $error("right mid code not half");
   a_left_peak_read: assert property (@(posedge clk) disable iff (!nrst)
      scl_fall && !start_c && !stop_c && state_q == ST_DEV_ACK && rw_q && sub_q == REG_LEFT_PEAK
      |=> shreg_q == {PEAK_PAD, $past(record_left_peak_code)}) else $error("left peak read wrong");
   a_right_peak_read: assert property (@(posedge clk) disable iff (!nrst)
      scl_fall && !start_c && !stop_c && sub_q == REG_RIGHT_PEAK
      && ((state_q == ST_DEV_ACK && rw_q) || (state_q == ST_RD_ACK && mack_q))
      |=> shreg_q == {PEAK_PAD, $past(record_right_peak_code)}) else $error("right peak read wrong");
   a_sysclk_src_rx: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_SYNTH_ONE && shreg_q[S1_SRC_LSB +: FIELD2_W] != SRC_RX
      |-> ##2 !third_sysclk_from_rx) else $error("receiver clock chosen by other code");
   a_ref_div_xtal: assert property (@(posedge clk) disable iff (!nrst)
      synth_ref_div == DIV_TWO |-> !synth_ref_from_mclk) else $error("master clock reference halved");
   a_synth_a_double: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_SYNTH_TWO && shreg_q[S2_A_LSB +: FIELD2_W] == RATE_44K1 && shreg_q[S2_A_DOUBLE]
      |-> ##2 synth_a_rate_hz == HZ_88K2) else $error("first synthesizer rate not doubled");
   a_synth_b_ratio: assert property (@(posedge clk) disable iff (!nrst)
      wr_stb && sub_q == REG_SYNTH_TWO && shreg_q[S2_B_RATIO]
      |-> ##2 synth_b_os_ratio == OSR_384) else $error("second synthesizer ratio not 384");

endmodule : apc_regbank

// *** tb/apc_regbank_bench.sv ***
// Self-checking bench for the record-path and synthesizer register bank.
module apc_regbank_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import apc_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, scl_m = 1'b1, sda_m = 1'b1, synth_ref_select = 1'b0;
   logic [5:0]  record_left_peak_code = 6'h00, record_right_peak_code = 6'h00;
   logic        sda_o, sda_oe, ref_buffer_sleep, third_sysclk_from_rx, synth_ref_from_mclk, synth_a_sleep;
   logic        synth_b_sleep, oscillator_sleep, synth_a_rate_bad, synth_b_rate_bad;
   logic [1:0]  record_div_ratio, master_clock_div, synth_ref_div, record_clock_divider, third_sysclk_source;
   logic [8:0]  record_left_gain_num, record_right_gain_num, s1v [3] = '{9'h0F0, 9'h14F, 9'h190};
   logic [9:0]  third_sysclk_ratio, synth_a_os_ratio, synth_b_os_ratio;
   logic [16:0] synth_a_rate_hz, synth_b_rate_hz, hz;
   logic [7:0]  v, record_left_gain_code, record_right_gain_code;
   wire         sda_wire;
   int          error_cnt = 0, total_checks = 0;

   apc_regbank dut_u (
      .clk, .nrst, .scl_i(scl_m), .sda_i(sda_wire), .sda_o, .sda_oe,
      .record_left_peak_code, .record_right_peak_code, .synth_ref_select,
      .record_clock_divider, .record_div_ratio, .ref_buffer_sleep, .record_left_gain_code,
      .record_right_gain_code, .record_left_gain_num, .record_right_gain_num, .third_sysclk_source,
      .third_sysclk_from_rx, .third_sysclk_ratio, .master_clock_div, .synth_ref_div, .synth_ref_from_mclk,
      .synth_a_sleep, .synth_b_sleep, .oscillator_sleep, .synth_a_rate_hz, .synth_a_os_ratio,
      .synth_a_rate_bad, .synth_b_rate_hz, .synth_b_os_ratio, .synth_b_rate_bad);

   // Open-drain data line: low when the master pulls it or the device drives its level.
   assign sda_wire = sda_m & (sda_oe ? sda_o : 1'b1);

   // Clock of 5 ns period.
   always #2.5 clk = ~clk;

   // Compares one value and counts the result.
   task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk

   // Sets both control pins just after an edge, then holds them eight cycles.
   task automatic pins(input logic c, input logic d);
      scl_m = c;
      sda_m = d;
      repeat (8) @(posedge clk);
      #1;
   endtask : pins

   // Sends nine bits MSB first and samples the line at each high phase.
   task automatic xfer(input logic [8:0] tx, input logic ack_chk, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         pins(1'b0, tx[i]);
         pins(1'b1, tx[i]);
         rx[i] = sda_wire;
         pins(1'b0, tx[i]);
      end
      if (ack_chk) chk("ack", 17'h0, rx[0]);
   endtask : xfer

   // Writes one register, reads it back over a repeated start and compares.
   task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      logic [8:0] r;
      for (int k = 0; k < 2; k++) begin
         pins(1'b0, 1'b1);
         pins(1'b1, 1'b1);
         pins(1'b1, 1'b0);
         pins(1'b0, 1'b0);
         xfer({DEV_ADDR_DEFAULT, k[0], 1'b1}, 1'b1, r);
         if (k == 0) xfer({a, 1'b1}, 1'b1, r);
         xfer(k == 0 ? {d, 1'b1} : 9'h1FF, k == 0, r);
         if (k == 0) begin
            pins(1'b0, 1'b0);
            pins(1'b1, 1'b0);
            pins(1'b1, 1'b1);
            pins(1'b1, 1'b1);
            pins(1'b0, 1'b0);
            pins(1'b0, 1'b1);
            pins(1'b1, 1'b1);
            pins(1'b1, 1'b0);
            pins(1'b0, 1'b0);
            xfer({DEV_ADDR_DEFAULT, 2'b01}, 1'b1, r);
            xfer({a, 1'b1}, 1'b1, r);
         end
      end
      chk("readback", e, r[8:1]);
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b0);
      pins(1'b1, 1'b1);
   endtask : wrc

   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   // Cuts a hang short well after the expected run length.
   initial begin
      #400000;
      error_cnt++;
      end_of_test;
   end

   // Main sequence of register accesses.
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      pins(1'b1, 1'b1);
      chk("sysclk_ratio", OSR_512, third_sysclk_ratio);
      wrc(8'h80, 8'h5A, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = {3'h0, i[0], 2'h0, i[1:0]};
         wrc(REG_CTRL_TWO, v | 8'hEC, v);
         chk("div_ratio", i == 1 ? 2 : i == 2 ? 3 : 1, record_div_ratio);
         chk("div_code", i[1:0], record_clock_divider);
         chk("buf_sleep", i[0], ref_buffer_sleep);
      end
      $display("test divider done");
      wrc(REG_LEFT_GAIN, 8'h7F, 8'h7F);
      wrc(REG_RIGHT_GAIN, 8'h00, 8'h00);
      chk("left_gain", GAIN_UNITY, record_left_gain_num);
      chk("right_gain", GAIN_MIN, record_right_gain_num);
      wrc(REG_LEFT_GAIN, 8'h40, 8'h40);
      wrc(REG_RIGHT_GAIN, 8'hFF, 8'hFF);
      chk("left_gain", GAIN_HALF, record_left_gain_num);
      chk("right_gain", GAIN_UNITY, record_right_gain_num);
      chk("left_code", 8'h40, record_left_gain_code);
      wrc(REG_RIGHT_GAIN, 8'hC0, 8'hC0);
      chk("right_gain", GAIN_HALF, record_right_gain_num);
      chk("right_code", 8'hC0, record_right_gain_code);
      $display("test gain done");
      record_left_peak_code = 6'h3F;
      record_right_peak_code = 6'h01;
      wrc(REG_LEFT_PEAK, 8'h15, 8'h3F);
      wrc(REG_RIGHT_PEAK, 8'h15, 8'h01);
      $display("test peak done");
      foreach (s1v[j]) begin
         synth_ref_select = s1v[j][8];
         wrc(REG_SYNTH_ONE, s1v[j][7:0], s1v[j][7:0]);
         chk("from_rx", s1v[j][7:6] == 2'b11, third_sysclk_from_rx);
         chk("src_code", s1v[j][7:6], third_sysclk_source);
         chk("mclk_div", s1v[j][5] ? 2 : 1, master_clock_div);
         chk("ref_div", (s1v[j][4] && !s1v[j][8]) ? 2 : 1, synth_ref_div);
         chk("from_mclk", s1v[j][8], synth_ref_from_mclk);
         chk("sleeps", s1v[j][3:1], {synth_b_sleep, synth_a_sleep, oscillator_sleep});
         chk("sysclk_ratio", s1v[j][0] ? OSR_256 : OSR_512, third_sysclk_ratio);
      end
      $display("test synth one done");
      for (int c = 0; c < 4; c++) begin
         v = {c[1:0], ~c[0], c[0], c[1:0], c[0], c[1]};
         wrc(REG_SYNTH_TWO, v, v);
         hz = c == 0 ? HZ_48K : c == 2 ? HZ_32K : c == 3 ? HZ_44K1 : HZ_NONE;
         chk("b_hz", hz << c[0], synth_b_rate_hz);
         chk("a_hz", hz << c[1], synth_a_rate_hz);
         chk("b_os", c[0] ? OSR_256 : OSR_384, synth_b_os_ratio);
         chk("a_os", c[0] ? OSR_384 : OSR_256, synth_a_os_ratio);
         chk("bad", {2{c == 1}}, {synth_b_rate_bad, synth_a_rate_bad});
      end
      $display("test synth two done");
      end_of_test;
   end
endmodule : apc_regbank_bench
